// *** strap_capture_mgmt_pin_mux.v ***
`timescale 1ns/10ps
`include "strap_consts.vh"
// Notes on behaviour
// RQ1: Three interface strap bits pick 16-bit, 8-bit, serial plus frame, or serial only.
// RQ2: Code 111 turns address pins 0 and 1 into EEPROM data and clock.
// RQ3: Parallel host drives address, write, read, select over 16 or 8 data bits.
// RQ4: Serial modes reuse write as strobe, read as data out, select as data in.
// RQ5: Serial plus frame mode maps frame transmit and receive signals onto data pins.
// RQ6: All test straps and transmit-enable straps are sampled at reset. The code samples the transmit-enable straps only when strap bit 9 is set.
// RQ7: Strap bit 0 enables debounce on serial inputs in serial modes.
// RQ8: Strap bits 6 to 4 give the serial device identifier.
// RQ9: Unmanaged mode loads configuration from EEPROM when strap bit 7 enables it.
// RQ10: The EEPROM strap is ignored outside unmanaged serial mode.
// RQ11: Code 111 is unmanaged, code 011 is lightly managed serial only.
// RQ12: Module hot-swap support is enabled only by strap bit 9.
// RQ13: With hot-swap on, transmit-enable straps become each port's module type.
// RQ14: Strap bit 11 lets each port MAC enter low power after inactivity.
// RQ15: A power-saving port MAC wakes as soon as activity returns.
// RQ16: Strap bit 12 flags any state machine busy over five seconds.
module strap_capture_mgmt_pin_mux #(
  parameter NUM_PORTS = 9,
  parameter NUM_FSM = 4,
  parameter [30:0] TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
  parameter [30:0] IDLE_CYCLES = `IDLE_CYCLES
) (
  // Clock, reset, enable
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // Strap pins
  input wire [15:0] strap_test_pins,
  input wire [7:0] fast_port_tx_en,
  input wire uplink_tx_en,
  input wire uplink_tx_err,
  // Management pins
  input wire [2:0] pin_addr_in,
  output reg [1:0] pin_addr_out,
  output reg [1:0] pin_addr_oe,
  input wire pin_we_b,
  input wire pin_rd_b_in,
  output reg pin_rd_out,
  output reg pin_rd_oe,
  input wire pin_cs_b,
  output reg pin_int_b,
  input wire [15:0] pin_data_in,
  output reg [15:0] pin_data_out,
  output reg [15:0] pin_data_oe,
  // Parallel host side toward core
  output reg [2:0] host_addr,
  output reg host_wr,
  output reg host_rd,
  output reg [15:0] host_wdata,
  input wire [15:0] host_rdata,
  // Serial side toward core
  output reg serial_strobe,
  output reg serial_sdi,
  input wire serial_sdo,
  // EEPROM side toward core
  input wire eeprom_sda_drive,
  input wire eeprom_scl_drive,
  output reg eeprom_sda_in,
  // Frame path side toward core
  input wire [3:0] cpu_frame_txd,
  input wire cpu_frame_tx_en,
  output reg cpu_frame_tx_clk,
  output reg cpu_frame_rx_clk,
  output reg [3:0] cpu_frame_rxd,
  output reg cpu_frame_rx_valid,
  // Interrupt from core, active high
  input wire core_irq,
  // Captured configuration
  output reg strap_valid,
  output reg [2:0] mgmt_mode,
  output reg unmanaged,
  output reg lightly_managed,
  output reg debounce_en,
  output reg [2:0] serial_dev_id,
  output reg eeprom_load_en,
  output reg hotswap_en,
  output reg [7:0] fast_port_module_type,
  output reg [1:0] uplink_module_type,
  output reg power_save_en,
  output reg timeout_en,
  // Power saving
  input wire [NUM_PORTS-1:0] port_activity,
  output reg [NUM_PORTS-1:0] port_power_save,
  // Stuck state monitor
  input wire [NUM_FSM-1:0] fsm_busy,
  output reg [NUM_FSM-1:0] fsm_stuck,
  output reg timeout_reset
);

  // Divider half period, cut on purpose to the counter width
  localparam integer HALF_CYCLES = `FRAME_CLK_HALF;
  localparam [3:0] HALF = HALF_CYCLES[3:0];

  // ----------------------------------------
  // Mode helpers
  // ----------------------------------------
  function is_serial;
    input [2:0] m;
    begin
      is_serial = (m == `MODE_SER_MII) || (m == `MODE_SER_LITE) || (m == `MODE_SER_UNMGD);
    end
  endfunction

  function is_parallel;
    input [2:0] m;
    begin
      is_parallel = (m == `MODE_PAR16) || (m == `MODE_PAR8);
    end
  endfunction

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  reg [15:0] strap;
  reg [2:0] mode;

  // Sampled on first enabled edge after release; a reset can only load constants
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap <= `STRAP_RESET;
      strap_valid <= 1'b0;
      fast_port_module_type <= 8'h00;
      uplink_module_type <= 2'h0;
    end else if (clk_en && !strap_valid) begin
      strap <= strap_test_pins; // [RQ6]
      strap_valid <= 1'b1;
      if (strap_test_pins[`STRAP_HOTSWAP]) begin
        fast_port_module_type <= fast_port_tx_en; // [RQ13]
        uplink_module_type <= {uplink_tx_err, uplink_tx_en}; // [RQ13]
      end
    end
  end

  // Interface code, legal codes only; unknown codes fall back to serial only
  always @* begin
    mode = strap[`STRAP_MODE_HI:`STRAP_MODE_LO];
    case (mode)
      `MODE_PAR16, `MODE_PAR8, `MODE_SER_MII, `MODE_SER_LITE, `MODE_SER_UNMGD: mode = mode; // [RQ1]
      default: mode = `MODE_SER_LITE;
    endcase
  end

  // Configuration outputs derived from the captured straps
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_mode <= `MODE_RESET;
      unmanaged <= 1'b0;
      lightly_managed <= 1'b0;
      debounce_en <= 1'b0;
      serial_dev_id <= 3'h0;
      eeprom_load_en <= 1'b0;
      hotswap_en <= 1'b0;
      power_save_en <= 1'b0;
      timeout_en <= 1'b0;
    end else if (clk_en && strap_valid) begin
      mgmt_mode <= mode; // [RQ1]
      unmanaged <= (mode == `MODE_SER_UNMGD); // [RQ11]
      lightly_managed <= (mode == `MODE_SER_LITE); // [RQ11]
      debounce_en <= is_serial(mode) && strap[`STRAP_DEBOUNCE]; // [RQ7]
      serial_dev_id <= is_serial(mode) ? strap[`STRAP_ID_HI:`STRAP_ID_LO] : 3'h0; // [RQ8]
      // Pulled low to enable; meaningless in any managed mode
      eeprom_load_en <= (mode == `MODE_SER_UNMGD) && !strap[`STRAP_EEPROM]; // [RQ9] [RQ10]
      hotswap_en <= strap[`STRAP_HOTSWAP]; // [RQ12]
      power_save_en <= strap[`STRAP_PWRSAVE]; // [RQ14]
      timeout_en <= strap[`STRAP_TIMEOUT]; // [RQ16]
    end
  end

  // ----------------------------------------
  // Serial input debounce
  // ----------------------------------------
  reg [`DEBOUNCE_SAMPLES-1:0] strobe_hist;
  reg [`DEBOUNCE_SAMPLES-1:0] sdi_hist;
  reg strobe_clean;
  reg sdi_clean;

  // Filtered level moves only after all samples agree; costs a few cycles of latency
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_hist <= {`DEBOUNCE_SAMPLES{1'b1}};
      sdi_hist <= {`DEBOUNCE_SAMPLES{1'b1}};
      strobe_clean <= 1'b1;
      sdi_clean <= 1'b1;
    end else if (clk_en) begin
      strobe_hist <= {strobe_hist[`DEBOUNCE_SAMPLES-2:0], pin_we_b};
      sdi_hist <= {sdi_hist[`DEBOUNCE_SAMPLES-2:0], pin_cs_b};
      if (&strobe_hist)
        strobe_clean <= 1'b1;
      else if (~|strobe_hist)
        strobe_clean <= 1'b0;
      if (&sdi_hist)
        sdi_clean <= 1'b1;
      else if (~|sdi_hist)
        sdi_clean <= 1'b0;
    end
  end

  // ----------------------------------------
  // Frame clock divider
  // ----------------------------------------
  reg [3:0] div_count;
  reg frame_clk;

  // Device sources both frame clocks toward the host
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_count <= 4'h0;
      frame_clk <= 1'b0;
    end else if (clk_en) begin
      if (div_count == HALF - 1'b1) begin
        div_count <= 4'h0;
        frame_clk <= ~frame_clk;
      end else begin
        div_count <= div_count + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Pin mux
  // ----------------------------------------
  wire par_cycle = !pin_cs_b && is_parallel(mode);

  // Every pin except pin_int_b stays undriven until straps are captured
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_addr_out <= 2'h0;
      pin_addr_oe <= 2'h0;
      pin_rd_out <= 1'b0;
      pin_rd_oe <= 1'b0;
      pin_int_b <= 1'b1;
      pin_data_out <= `DATA_RESET;
      pin_data_oe <= `DATA_RESET;
      host_addr <= 3'h0;
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      host_wdata <= `DATA_RESET;
      serial_strobe <= 1'b1;
      serial_sdi <= 1'b1;
      eeprom_sda_in <= 1'b1;
      cpu_frame_tx_clk <= 1'b0;
      cpu_frame_rx_clk <= 1'b0;
      cpu_frame_rxd <= 4'h0;
      cpu_frame_rx_valid <= 1'b0;
    end else if (clk_en) begin
      pin_int_b <= ~core_irq; // [RQ4]
      pin_addr_out <= 2'h0;
      pin_addr_oe <= 2'h0;
      pin_rd_out <= 1'b0;
      pin_rd_oe <= 1'b0;
      pin_data_out <= `DATA_RESET;
      pin_data_oe <= `DATA_RESET;
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      cpu_frame_tx_clk <= frame_clk;
      cpu_frame_rx_clk <= frame_clk;
      if (strap_valid) begin
        if (is_parallel(mode)) begin
          host_addr <= pin_addr_in; // [RQ3]
          host_wr <= par_cycle && !pin_we_b; // [RQ3]
          host_rd <= par_cycle && !pin_rd_b_in; // [RQ3]
          if (mode == `MODE_PAR16) begin
            host_wdata <= pin_data_in; // [RQ3]
            pin_data_out <= host_rdata;
            pin_data_oe <= (par_cycle && !pin_rd_b_in) ? 16'hffff : 16'h0000;
          end else begin
            // Upper byte is not used in the narrow bus
            host_wdata <= {8'h00, pin_data_in[7:0]}; // [RQ3]
            pin_data_out <= {8'h00, host_rdata[7:0]};
            pin_data_oe <= (par_cycle && !pin_rd_b_in) ? 16'h00ff : 16'h0000;
          end
        end else begin
          serial_strobe <= debounce_en ? strobe_clean : pin_we_b; // [RQ4] [RQ7]
          serial_sdi <= debounce_en ? sdi_clean : pin_cs_b; // [RQ4] [RQ7]
          pin_rd_out <= serial_sdo; // [RQ4]
          pin_rd_oe <= 1'b1; // [RQ4]
          if (mode == `MODE_SER_UNMGD) begin
            pin_addr_out <= {eeprom_scl_drive, 1'b0}; // [RQ2]
            // Open-drain data line: drive only the low level
            pin_addr_oe <= {1'b1, !eeprom_sda_drive}; // [RQ2]
            eeprom_sda_in <= pin_addr_in[0]; // [RQ2]
          end
          if (mode == `MODE_SER_MII) begin
            pin_data_out[`PIN_TXD_LO +: 4] <= cpu_frame_txd; // [RQ5]
            pin_data_out[`PIN_TX_CLK] <= frame_clk; // [RQ5]
            pin_data_out[`PIN_TX_EN] <= cpu_frame_tx_en; // [RQ5]
            pin_data_out[`PIN_RX_CLK] <= frame_clk; // [RQ5]
            pin_data_oe <= `FRAME_TX_OE | `FRAME_RX_OE; // [RQ5]
            cpu_frame_rxd <= pin_data_in[`PIN_RXD_LO +: 4]; // [RQ5]
            cpu_frame_rx_valid <= pin_data_in[`PIN_RX_VALID]; // [RQ5]
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Port MAC power saving
  // ----------------------------------------
  wire [NUM_PORTS-1:0] idle_expired;
  wire [NUM_FSM-1:0] busy_expired;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi = gi + 1) begin : g_idle
      level_timer #(.W(31), .LIMIT(IDLE_CYCLES)) u_idle (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .run(power_save_en && !port_activity[gi]),
        .expired(idle_expired[gi])
      );
    end
    for (gi = 0; gi < NUM_FSM; gi = gi + 1) begin : g_busy
      level_timer #(.W(31), .LIMIT(TIMEOUT_CYCLES)) u_busy (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .run(timeout_en && fsm_busy[gi]),
        .expired(busy_expired[gi])
      );
    end
  endgenerate

  // Activity in this cycle wakes the port without waiting on the timer
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port_power_save <= {NUM_PORTS{1'b0}};
    end else if (clk_en) begin
      port_power_save <= {NUM_PORTS{power_save_en}} & idle_expired & ~port_activity; // [RQ14] [RQ15]
    end
  end

  // ----------------------------------------
  // Stuck state monitor
  // ----------------------------------------
  // One reset pulse per cycle in which any machine newly sticks, not a continuous reset
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fsm_stuck <= {NUM_FSM{1'b0}};
      timeout_reset <= 1'b0;
    end else if (clk_en) begin
      fsm_stuck <= {NUM_FSM{timeout_en}} & busy_expired & fsm_busy; // [RQ16]
      timeout_reset <= |({NUM_FSM{timeout_en}} & busy_expired & fsm_busy & ~fsm_stuck); // [RQ16]
    end
  end

endmodule // strap_capture_mgmt_pin_mux

// *** strap_consts.vh ***
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH

// ----------------------------------------
// Management interface strap codes
// ----------------------------------------
`define MODE_PAR16 3'h0
`define MODE_PAR8 3'h1
`define MODE_SER_MII 3'h2
`define MODE_SER_LITE 3'h3
`define MODE_SER_UNMGD 3'h7

// ----------------------------------------
// Strap bit positions
// ----------------------------------------
`define STRAP_DEBOUNCE 0
`define STRAP_MODE_LO 1
`define STRAP_MODE_HI 3
`define STRAP_ID_LO 4
`define STRAP_ID_HI 6
`define STRAP_EEPROM 7
`define STRAP_HOTSWAP 9
`define STRAP_PWRSAVE 11
`define STRAP_TIMEOUT 12

// ----------------------------------------
// Reset values
// ----------------------------------------
`define STRAP_RESET 16'h0000
`define MODE_RESET 3'h7
`define DATA_RESET 16'h0000

// ----------------------------------------
// Shared data pin roles in serial plus frame mode
// ----------------------------------------
`define PIN_TXD_LO 0
`define PIN_TX_CLK 4
`define PIN_TX_EN 5
`define PIN_RXD_LO 8
`define PIN_RX_CLK 12
`define PIN_RX_VALID 13
`define FRAME_TX_OE 16'h003f
`define FRAME_RX_OE 16'h1000

// ----------------------------------------
// Timing
// ----------------------------------------
`define REF_CLK_MHZ 250
`define FRAME_CLK_MHZ 25
`define FRAME_CLK_HALF (`REF_CLK_MHZ / (2 * `FRAME_CLK_MHZ))
`define TIMEOUT_SEC 5
`define TIMEOUT_CYCLES (`TIMEOUT_SEC * `REF_CLK_MHZ * 1000000)
`define IDLE_CYCLES 1024
`define DEBOUNCE_SAMPLES 3

`endif

// *** level_timer.v ***
`timescale 1ns/10ps
// ----------------------------------------
// Saturating timer: expired once run held LIMIT cycles
// ----------------------------------------
module level_timer #(
  parameter W = 31,
  parameter [W-1:0] LIMIT = 1024
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // Control
  input wire run,
  output reg expired
);

  reg [W-1:0] count;

  // Count while run is high, clear at once when it drops
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= {W{1'b0}};
      expired <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count <= {W{1'b0}};
        expired <= 1'b0;
      end else if (count >= LIMIT - 1'b1) begin
        // Saturate so a long stall cannot wrap and re-arm
        expired <= 1'b1;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule // level_timer

// *** strap_mux_asserts.sv ***
`timescale 1ns/10ps
// --------
// Port checker for the strap pin mux
// --------
module strap_mux_asserts #(
  parameter NUM_PORTS = 9
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst_b,
  input wire clk_en,
  // Pins and core inputs
  input wire pin_cs_b,
  input wire pin_rd_b_in,
  input wire core_irq,
  input wire serial_sdo,
  input wire eeprom_sda_drive,
  input wire eeprom_scl_drive,
  input wire [NUM_PORTS-1:0] port_activity,
  // Design outputs
  input wire pin_int_b,
  input wire [15:0] pin_data_oe,
  input wire [1:0] pin_addr_oe,
  input wire [1:0] pin_addr_out,
  input wire pin_rd_oe,
  input wire pin_rd_out,
  input wire host_wr,
  input wire host_rd,
  input wire strap_valid,
  input wire [2:0] mgmt_mode,
  input wire unmanaged,
  input wire eeprom_load_en,
  input wire power_save_en,
  input wire timeout_en,
  input wire [NUM_PORTS-1:0] port_power_save,
  input wire timeout_reset
);
  reg cfg_ok;
  wire go;
  // Config is trusted one edge after capture, as the mux lags it
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_ok <= 1'b0;
    end else begin
      cfg_ok <= strap_valid;
    end
  end
  assign go = cfg_ok & clk_en;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // --------
  // Assertions
  // --------
  int_level_a: assert property (clk_en |=> pin_int_b == !$past(core_irq))
    else $error("interrupt pin not inverse of request");
  par16_read_a: assert property (go && mgmt_mode == 3'h0 && !pin_cs_b && !pin_rd_b_in |=> pin_data_oe == 16'hffff)
    else $error("wide read does not drive all data pins");
  par8_read_a: assert property (go && mgmt_mode == 3'h1 && !pin_cs_b && !pin_rd_b_in |=> pin_data_oe == 16'h00ff)
    else $error("byte read drives wrong data pins");
  no_select_a: assert property (go && mgmt_mode < 3'h2 && pin_cs_b |=> !host_wr && !host_rd)
    else $error("access passed without chip select");
  eeprom_pins_a: assert property (go && mgmt_mode == 3'h7 |=>
    pin_addr_oe == {1'b1, !$past(eeprom_sda_drive)} && pin_addr_out == {$past(eeprom_scl_drive), 1'b0})
    else $error("eeprom pins wrongly driven");
  lite_pins_a: assert property (go && mgmt_mode == 3'h3 |=> pin_addr_oe == 2'b00)
    else $error("address pins driven in lightly managed mode");
  frame_oe_a: assert property (go && mgmt_mode == 3'h2 |=> pin_data_oe == 16'h103f)
    else $error("frame path drives wrong data pins");
  serial_out_a: assert property (go && mgmt_mode > 3'h1 |=> pin_rd_oe && pin_rd_out == $past(serial_sdo))
    else $error("serial data out not on read pin");
  mode_flag_a: assert property (cfg_ok |-> unmanaged == (mgmt_mode == 3'h7))
    else $error("unmanaged flag disagrees with mode");
  eeprom_gate_a: assert property (eeprom_load_en |-> unmanaged)
    else $error("eeprom load outside unmanaged mode");
  wake_up_a: assert property (clk_en |=> (port_power_save & $past(port_activity)) == 0)
    else $error("port stays asleep with activity");
  save_gate_a: assert property (port_power_save != 0 |-> power_save_en)
    else $error("power save while disabled");
  stuck_pulse_a: assert property (timeout_reset |-> timeout_en ##1 !timeout_reset)
    else $error("timeout reset not a single enabled pulse");
  cover property (go && mgmt_mode == 3'h2);
  cover property ($rose(port_power_save[0]));
  cover property (timeout_reset);
endmodule // strap_mux_asserts

bind strap_capture_mgmt_pin_mux strap_mux_asserts #(.NUM_PORTS(NUM_PORTS)) strap_mux_asserts_i (
  .ref_clk, .rst_b, .clk_en, .pin_cs_b, .pin_rd_b_in, .core_irq, .serial_sdo, .eeprom_sda_drive,
  .eeprom_scl_drive, .port_activity, .pin_int_b, .pin_data_oe, .pin_addr_oe, .pin_addr_out, .pin_rd_oe,
  .pin_rd_out, .host_wr, .host_rd, .strap_valid, .mgmt_mode, .unmanaged, .eeprom_load_en, .power_save_en,
  .timeout_en, .port_power_save, .timeout_reset
);

// *** mgmt_bus_model.sv ***
`timescale 1ns/10ps
// --------
// Host bus and EEPROM side of the pins
// --------
module mgmt_bus_model (
  // Clock
  input wire ref_clk,
  // Host and EEPROM drive
  input wire [15:0] host_drive,
  input wire host_oe,
  input wire [2:0] host_pin_addr,
  input wire eeprom_pull,
  // Device pins
  input wire [15:0] pin_data_out,
  input wire [15:0] pin_data_oe,
  input wire [1:0] pin_addr_out,
  input wire [1:0] pin_addr_oe,
  output wire [15:0] pin_data_in,
  output wire [2:0] pin_addr_in
);
  reg [15:0] last = 16'h0000;
  wire sda;
  // Released lines flip each cycle, so stale data never reads back
  assign pin_data_in = (pin_data_oe & pin_data_out) | (~pin_data_oe & (host_oe ? host_drive : ~last));
  always @(posedge ref_clk) begin
    last <= pin_data_in;
  end
  // Open-drain data with pull-up; either side may pull low
  assign sda = ~((pin_addr_oe[0] & ~pin_addr_out[0]) | eeprom_pull);
  assign pin_addr_in = {host_pin_addr[2:1], host_pin_addr[0] & sda};
endmodule // mgmt_bus_model

// *** strap_capture_mgmt_pin_mux_tb_top.sv ***
`timescale 1ns/10ps
module strap_capture_mgmt_pin_mux_tb_top;
  reg ref_clk, rst_b, clk_en, uplink_tx_en, uplink_tx_err, pin_we_b, pin_rd_b_in, pin_cs_b, serial_sdo;
  reg eeprom_sda_drive, eeprom_scl_drive, cpu_frame_tx_en, core_irq, host_oe, eeprom_pull;
  reg [15:0] strap_test_pins, host_rdata, host_drive;
  reg [7:0] fast_port_tx_en;
  reg [3:0] cpu_frame_txd, fsm_busy;
  reg [2:0] host_pin_addr;
  reg [8:0] port_activity;
  wire [15:0] pin_data_in, pin_data_out, pin_data_oe, host_wdata;
  wire [8:0] port_power_save;
  wire [7:0] fast_port_module_type;
  wire [3:0] cpu_frame_rxd, fsm_stuck;
  wire [2:0] pin_addr_in, host_addr, mgmt_mode, serial_dev_id;
  wire [1:0] pin_addr_out, pin_addr_oe, uplink_module_type;
  wire pin_rd_out, pin_rd_oe, pin_int_b, host_wr, host_rd, serial_strobe, serial_sdi, eeprom_sda_in;
  wire cpu_frame_tx_clk, cpu_frame_rx_clk, cpu_frame_rx_valid, strap_valid, unmanaged, lightly_managed;
  wire debounce_en, eeprom_load_en, hotswap_en, power_save_en, timeout_en, timeout_reset;
  integer miscompares = 0, checked = 0, cycles = 0, n, m;
  // Short counts keep the idle and stuck waits brief
  strap_capture_mgmt_pin_mux #(.TIMEOUT_CYCLES(31'd50), .IDLE_CYCLES(31'd8)) strap_capture_mgmt_pin_mux_i (.*);
  mgmt_bus_model mgmt_bus_model_i (.*);
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  // --------
  // Tasks
  // --------
  task cyc(input integer k);
    repeat (k) @(negedge ref_clk);
  endtask
  task chk(input string what, input [15:0] exp, input [15:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      $display("ERROR %0s expected %h seen %h", what, exp, got);
      miscompares = miscompares + 1;
    end
  endtask
  // Straps stay steady through reset and the capture edge
  task boot(input [15:0] s, input [9:0] mt);
    strap_test_pins = s;
    {uplink_tx_err, uplink_tx_en, fast_port_tx_en} = mt;
    rst_b = 1'b0;
    cyc(4);
    chk("strap_held", 16'h0000, {15'h0000, strap_valid});
    rst_b = 1'b1;
    cyc(3);
    chk("strap_valid", 16'h0001, {15'h0000, strap_valid});
  endtask
  task print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // --------
  // Tests
  // --------
  initial begin
    {clk_en, pin_we_b, pin_rd_b_in, pin_cs_b, eeprom_sda_drive} = 5'h1f;
    {serial_sdo, eeprom_scl_drive, cpu_frame_tx_en, core_irq, host_oe, eeprom_pull} = 6'h00;
    {host_rdata, host_drive} = 32'h0000_0000;
    {cpu_frame_txd, fsm_busy, host_pin_addr} = 11'h000;
    port_activity = 9'h1ff;
    // Wide then byte host port; serial straps set but ignored
    for (m = 0; m < 2; m = m + 1) begin
      boot(m ? 16'h0273 : 16'h0271, 10'h25a);
      chk("mgmt_mode", m[15:0], {13'h0000, mgmt_mode});
      chk("port_types", 16'h025a, {uplink_module_type, fast_port_module_type});
      chk("serial_opts", 16'h0001, {debounce_en, serial_dev_id, eeprom_load_en, hotswap_en});
      host_rdata = 16'hbeef;
      {pin_cs_b, pin_rd_b_in} = 2'b00;
      cyc(1);
      chk("read_oe", m ? 16'h00ff : 16'hffff, pin_data_oe);
      chk("read_data", m ? 16'h00ef : 16'hbeef, pin_data_out & pin_data_oe);
      chk("host_rd", 16'h0001, {15'h0000, host_rd});
      {pin_cs_b, pin_rd_b_in, pin_we_b, host_oe} = 4'b1101;
      {host_drive, host_pin_addr} = {16'h1234, 3'h5};
      cyc(1);
      chk("no_select", 16'h0000, {14'h0000, host_wr, host_rd});
      pin_cs_b = 1'b0;
      cyc(1);
      chk("host_wdata", m ? 16'h0034 : 16'h1234, host_wdata);
      chk("host_wr_addr", 16'h000d, {12'h000, host_wr, host_addr});
      {pin_cs_b, pin_we_b, host_oe, core_irq} = 4'b1101;
      cyc(1);
      chk("int_low", 16'h0000, {15'h0000, pin_int_b});
      core_irq = 1'b0;
      cyc(1);
      chk("int_high", 16'h0001, {15'h0000, pin_int_b});
    end
    // Serial plus frame path, id 5, hot-swap off
    boot(16'h0054, 10'h3ff);
    chk("frame_cfg", 16'h4005, {mgmt_mode, hotswap_en, fast_port_module_type, debounce_en, serial_dev_id});
    {cpu_frame_txd, cpu_frame_tx_en, host_oe, pin_we_b, pin_cs_b, serial_sdo} = 9'h159;
    host_drive = 16'h2500;
    cyc(2);
    chk("frame_oe", 16'h103f, pin_data_oe);
    chk("frame_tx", 16'h002a, pin_data_out & 16'h002f);
    chk("frame_rx", 16'h0015, {11'h000, cpu_frame_rx_valid, cpu_frame_rxd});
    chk("serial_pins", 16'h0003, {12'h000, serial_strobe, serial_sdi, pin_rd_oe, pin_rd_out});
    n = 0;
    // Both frame clocks and their pin copies must toggle together
    repeat (20) begin
      m = {cpu_frame_tx_clk, cpu_frame_rx_clk, pin_data_out[4], pin_data_out[12]};
      cyc(1);
      n = n + $countones(m[3:0] ^ {cpu_frame_tx_clk, cpu_frame_rx_clk, pin_data_out[4], pin_data_out[12]});
    end
    chk("frame_clk_edges", 16'h0010, n[15:0]);
    {cpu_frame_tx_en, host_oe, pin_we_b, pin_cs_b} = 4'b0011;
    // Unlisted interface code falls back to lightly managed serial only
    boot(16'h000b, 10'h000);
    chk("odd_code", 16'h0007, {12'h000, mgmt_mode, lightly_managed});
    // Lightly managed serial only, eeprom strap set but ignored
    boot(16'h0006, 10'h000);
    chk("lite_cfg", 16'h0008, {11'h000, unmanaged, lightly_managed, eeprom_load_en, pin_addr_oe});
    // Unmanaged with eeprom, debounce, power save and timeout
    boot(16'h180f, 10'h000);
    chk("unmgd_cfg", 16'h001f, {11'h000, unmanaged, eeprom_load_en, debounce_en, power_save_en, timeout_en});
    {eeprom_scl_drive, eeprom_sda_drive, host_pin_addr} = 5'b10001;
    cyc(3);
    chk("eeprom_drive", 16'h001c, {11'h000, pin_addr_oe, pin_addr_out, eeprom_sda_in});
    {eeprom_sda_drive, eeprom_pull} = 2'b11;
    cyc(3);
    chk("eeprom_pulled", 16'h0014, {11'h000, pin_addr_oe, pin_addr_out, eeprom_sda_in});
    eeprom_pull = 1'b0;
    cyc(3);
    chk("eeprom_free", 16'h0015, {11'h000, pin_addr_oe, pin_addr_out, eeprom_sda_in});
    pin_we_b = 1'b0;
    cyc(2);
    chk("strobe_filtered", 16'h0001, {15'h0000, serial_strobe});
    cyc(6);
    chk("strobe_settled", 16'h0000, {15'h0000, serial_strobe});
    port_activity = 9'h000;
    cyc(4);
    chk("save_early", 16'h0000, {7'h00, port_power_save});
    cyc(12);
    chk("save_on", 16'h01ff, {7'h00, port_power_save});
    port_activity = 9'h001;
    cyc(1);
    chk("wake", 16'h01fe, {7'h00, port_power_save});
    // Enable low must freeze the sleep state despite new activity
    clk_en = 1'b0;
    port_activity = 9'h1ff;
    cyc(3);
    chk("frozen", 16'h01fe, {7'h00, port_power_save});
    clk_en = 1'b1;
    fsm_busy = 4'h1;
    n = 0;
    while (timeout_reset !== 1'b1 && n < 100) begin
      cyc(1);
      n = n + 1;
    end
    chk("stuck_wait", 16'h0001, {15'h0000, n > 45 && n < 60});
    chk("stuck", 16'h0001, {12'h000, fsm_stuck});
    fsm_busy = 4'h0;
    cyc(2);
    chk("unstuck", 16'h0000, {12'h000, fsm_stuck});
    print_verdict;
  end
endmodule // strap_capture_mgmt_pin_mux_tb_top
